// ===== hdl/sar_ctrl.sv
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sar_cfg.svh"

module sar_ctrl
  import sar_pkg::*;
#(
  parameter int BITS = 14,
  parameter int TRIAL_CYC = 4,
  parameter int STALE_CYC = `SAR_STALE_US * `SAR_CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic convert_start_n,
  input wire logic mode_fast,
  input wire logic mode_low_power,
  input wire logic range_bipolar,
  input wire logic range_ten,
  input wire logic comp_above,
  output logic busy,
  output logic sample_track,
  output logic [BITS-1:0] dac_code,
  output logic [BITS-1:0] result_code,
  output logic power_down,
  output logic bipolar_sel,
  output logic ten_sel
);

  localparam int ACQ_CYC = `SAR_NS2CYC(`SAR_ACQ_NS);
  localparam int PER_FAST = `SAR_NS2CYC(`SAR_PER_FAST_NS);
  localparam int PER_NORM = `SAR_NS2CYC(`SAR_PER_NORM_NS);
  localparam int PER_LOWP = `SAR_NS2CYC(`SAR_PER_LOWP_NS);
  localparam int IW = $clog2(BITS);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // both selects equal, high or low, fall through to normal
  function automatic sar_mode_e mode_of(input logic f, input logic l);
    if (f && !l) begin
      return SAR_FAST;
    end else if (!f && l) begin
      return SAR_LOWPWR;
    end
    return SAR_NORMAL;
  endfunction : mode_of

  function automatic logic [1:0] mode_code(input sar_mode_e m);
    case (m)
      SAR_FAST: mode_code = `SAR_MF_FAST;
      SAR_LOWPWR: mode_code = `SAR_MF_LOWPWR;
      default: mode_code = `SAR_MF_NORMAL;
    endcase
  endfunction : mode_code

  function automatic logic [15:0] min_period(input sar_mode_e m);
    case (m)
      SAR_FAST: min_period = 16'(PER_FAST);
      SAR_LOWPWR: min_period = 16'(PER_LOWP);
      default: min_period = 16'(PER_NORM);
    endcase
  endfunction : min_period

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic start_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle pin levels, so no false start edge or range blip after reset
      pin_s1_r <= 6'h01;
      pin_s2_r <= 6'h01;
      start_d_r <= 1'b1;
    end else begin
      pin_s1_r <= {comp_above, range_ten, range_bipolar, mode_low_power,
                   mode_fast, convert_start_n};
      pin_s2_r <= pin_s1_r;
      start_d_r <= pin_s2_r[0];
    end
  end

  logic start_fall;
  logic comp_s;
  assign start_fall = start_d_r && !pin_s2_r[0];
  assign comp_s = pin_s2_r[5];

  // -------------------------------------------------------------
  // configuration register
  // -------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic apb_wr;
  logic apb_rd;
  // a write lands on the completion edge, when pready is seen high
  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_rd = psel && penable && !pwrite && !pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `SAR_CTRL_RST;
    end else if (apb_wr && paddr == `SAR_CTRL_OFS) begin
      ctrl_r <= {27'h0, pwdata[4:0]};
    end
  end

  sar_mode_e req_mode;
  logic req_bip;
  logic req_ten;

  // with the register in charge the mode and range pins are ignored
  always_comb begin
    if (ctrl_r[`SAR_CTRL_SW]) begin
      req_mode = mode_of(ctrl_r[`SAR_CTRL_MODE_LO],
                         ctrl_r[`SAR_CTRL_MODE_LO+1]);
      req_bip = ctrl_r[`SAR_CTRL_BIP];
      req_ten = ctrl_r[`SAR_CTRL_TEN];
    end else begin
      req_mode = mode_of(pin_s2_r[1], pin_s2_r[2]);
      req_bip = pin_s2_r[3];
      req_ten = pin_s2_r[4];
    end
  end

  // -------------------------------------------------------------
  // active configuration and acquisition timer
  // -------------------------------------------------------------
  sar_state_e state_r;
  sar_mode_e mode_r;
  logic [15:0] acq_cnt_r;
  logic acq_done;
  logic cfg_change;
  logic start_ok;
  logic [15:0] per_cnt_r;
  logic [31:0] idle_cnt_r;

  assign acq_done = acq_cnt_r >= 16'(ACQ_CYC);
  assign cfg_change = req_mode != mode_r || req_bip != bipolar_sel
                      || req_ten != ten_sel;
  // a refused start is dropped; the host needs a new falling edge
  assign start_ok = state_r == SAR_IDLE && acq_done && !cfg_change
                    && per_cnt_r >= min_period(mode_r)
                    && start_fall;

  // range/mode switch only while tracking, then a full acquisition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= SAR_NORMAL;
      bipolar_sel <= 1'b0;
      ten_sel <= 1'b0;
    end else if (state_r == SAR_IDLE && cfg_change) begin
      mode_r <= req_mode;
      bipolar_sel <= req_bip;
      ten_sel <= req_ten;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_cnt_r <= 16'h0000;
    end else if (state_r != SAR_IDLE || cfg_change) begin
      acq_cnt_r <= 16'h0000;
    end else if (!acq_done) begin
      acq_cnt_r <= acq_cnt_r + 16'h0001;
    end
  end

  // cycles since the last accepted start, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_r <= 16'hFFFF;
      idle_cnt_r <= 32'hFFFF_FFFF;
    end else if (start_ok) begin
      per_cnt_r <= 16'h0001;
      idle_cnt_r <= 32'h0000_0001;
    end else begin
      if (per_cnt_r != 16'hFFFF) begin
        per_cnt_r <= per_cnt_r + 16'h0001;
      end
      if (idle_cnt_r != 32'hFFFF_FFFF) begin
        idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
      end
    end
  end

  // -------------------------------------------------------------
  // successive approximation sequencer
  // -------------------------------------------------------------
  logic [IW-1:0] bit_idx_r;
  logic [7:0] trial_cnt_r;
  logic stale_r;
  logic trial_end;
  // comparator passes the synchroniser, so a trial needs four cycles
  assign trial_end = trial_cnt_r == 8'(TRIAL_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SAR_IDLE;
      bit_idx_r <= '0;
      trial_cnt_r <= 8'h00;
      dac_code <= '0;
    end else begin
      case (state_r)
        SAR_IDLE: begin
          if (start_ok) begin
            state_r <= SAR_CONV;
            bit_idx_r <= IW'(BITS - 1);
            trial_cnt_r <= 8'h00;
            dac_code <= {1'b1, {(BITS-1){1'b0}}};
          end
        end
        SAR_CONV: begin
          if (!trial_end) begin
            trial_cnt_r <= trial_cnt_r + 8'h01;
          end else begin
            trial_cnt_r <= 8'h00;
            if (!comp_s) begin
              dac_code[bit_idx_r] <= 1'b0;
            end
            if (bit_idx_r == '0) begin
              state_r <= SAR_DONE;
            end else begin
              bit_idx_r <= bit_idx_r - IW'(1);
              dac_code[bit_idx_r - IW'(1)] <= 1'b1;
            end
          end
        end
        default: begin
          state_r <= SAR_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // result and busy
  // -------------------------------------------------------------
  // result is latched in the done cycle; busy drops with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_code <= '0;
      busy <= 1'b0;
    end else if (start_ok) begin
      busy <= 1'b1;
    end else if (state_r == SAR_DONE) begin
      result_code <= dac_code;
      busy <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // stale marker
  // -------------------------------------------------------------
  // stale marks a fast-mode result after a long gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stale_r <= 1'b0;
    end else if (start_ok) begin
      stale_r <= mode_r == SAR_FAST
                 && idle_cnt_r > 32'(STALE_CYC);
    end
  end

  // -------------------------------------------------------------
  // sample switch and power down
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_track <= 1'b1;
      power_down <= 1'b0;
    end else begin
      sample_track <= !(start_ok || state_r == SAR_CONV);
      power_down <= state_r == SAR_IDLE && !start_ok
                    && mode_r == SAR_LOWPWR && acq_done;
    end
  end

  // -------------------------------------------------------------
  // apb slave, one wait state
  // -------------------------------------------------------------
  // status shows the active configuration, not the requested one
  logic [31:0] stat_w;
  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[`SAR_STAT_BUSY] = busy;
    stat_w[`SAR_STAT_MODE_LO +: 2] = mode_code(mode_r);
    stat_w[`SAR_STAT_BIP] = bipolar_sel;
    stat_w[`SAR_STAT_TEN] = ten_sel;
    stat_w[`SAR_STAT_STALE] = stale_r;
    stat_w[`SAR_STAT_ACQ] = acq_done;
  end

  // an unmapped address answers with an error and zero data
  logic mapped;
  assign mapped = paddr == `SAR_CTRL_OFS || paddr == `SAR_STAT_OFS
                  || paddr == `SAR_RSLT_OFS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (apb_rd) begin
        if (paddr == `SAR_CTRL_OFS) begin
          prdata <= ctrl_r;
        end else if (paddr == `SAR_STAT_OFS) begin
          prdata <= stat_w;
        end else if (paddr == `SAR_RSLT_OFS) begin
          prdata <= {{(32-BITS){1'b0}}, result_code};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

endmodule : sar_ctrl
`default_nettype wire

// ===== hdl/sar_cfg.svh
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

// register byte offsets
`define SAR_CTRL_OFS 8'h00
`define SAR_STAT_OFS 8'h04
`define SAR_RSLT_OFS 8'h08

// control fields
`define SAR_CTRL_SW 0
`define SAR_CTRL_MODE_LO 1
`define SAR_CTRL_BIP 3
`define SAR_CTRL_TEN 4
`define SAR_CTRL_RST 32'h0000_0000

// status fields
`define SAR_STAT_BUSY 0
`define SAR_STAT_MODE_LO 1
`define SAR_STAT_BIP 3
`define SAR_STAT_TEN 4
`define SAR_STAT_STALE 5
`define SAR_STAT_ACQ 6

// mode field codes
`define SAR_MF_NORMAL 2'h0
`define SAR_MF_FAST 2'h1
`define SAR_MF_LOWPWR 2'h2

// timing
`define SAR_CLK_MHZ 125
`define SAR_ACQ_NS 250
`define SAR_PER_FAST_NS 1000
`define SAR_PER_NORM_NS 1250
`define SAR_PER_LOWP_NS 1493
`define SAR_STALE_US 1000
`define SAR_NS2CYC(ns) (((ns) * `SAR_CLK_MHZ + 999) / 1000)

`endif

// ===== hdl/sar_pkg.sv
`default_nettype none
package sar_pkg;
  typedef enum logic [1:0] {SAR_IDLE, SAR_CONV, SAR_DONE} sar_state_e;
  typedef enum logic [1:0] {SAR_NORMAL, SAR_FAST, SAR_LOWPWR} sar_mode_e;
endpackage : sar_pkg
`default_nettype wire

// ===== tb/sar_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_assertions #(
  parameter int BITS = 14,
  parameter int TRIAL_CYC = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busy,
  input wire logic sample_track,
  input wire logic [BITS-1:0] dac_code,
  input wire logic [BITS-1:0] result_code,
  input wire logic power_down
);
  int busy_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= busy ? busy_cnt_r + 1 : 0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  msb_first_a: assert property (
    $rose(busy) |-> dac_code == {1'b1, {(BITS-1){1'b0}}})
    else $error("first trial is not the top bit");
  busy_len_a: assert property (
    $fell(busy) |-> busy_cnt_r == BITS * TRIAL_CYC + 1)
    else $error("busy length wrong");
  hold_track_a: assert property (
    busy |-> !sample_track) else $error("tracking during conversion");
  result_fall_a: assert property (
    $changed(result_code) |-> $fell(busy))
    else $error("result moved outside busy fall");
  pwr_idle_a: assert property (
    power_down |-> !busy) else $error("powered down while busy");
  rdy_pulse_a: assert property (
    pready |=> !pready) else $error("ready longer than one cycle");
  apb_wait_a: assert property (
    psel && penable && !pready |=> pready) else $error("ready late");
  err_rdy_a: assert property (
    pslverr |-> pready) else $error("error without ready");
  unmapped_a: assert property (
    psel && penable && !pready &&
    !(paddr inside {8'h00, 8'h04, 8'h08}) |=> pslverr)
    else $error("unmapped access not refused");
endmodule : sar_ctrl_assertions
bind sar_ctrl sar_ctrl_assertions #(.BITS(BITS), .TRIAL_CYC(TRIAL_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .busy(busy),
  .sample_track(sample_track), .dac_code(dac_code),
  .result_code(result_code), .power_down(power_down));
`default_nettype wire

// ===== tb/sar_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module sar_afe_model #(
  parameter int BITS = 14
) (
  input wire logic pclk,
  input wire logic sample_track,
  input wire logic [BITS-1:0] dac_code,
  input wire logic [BITS-1:0] vin,
  output logic comp_above
);
  logic [BITS-1:0] held_r;
  // input follows while tracking, frozen once the hold begins
  always_ff @(posedge pclk) begin
    if (sample_track) begin
      held_r <= vin;
    end
  end
  // trial bit kept while the held input reaches the trial level
  assign comp_above = (held_r >= dac_code);
endmodule : sar_afe_model
`default_nettype wire

// ===== tb/tb_sar_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "sar_cfg.svh"
module tb_sar_ctrl;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, busy, sample_track, power_down, comp;
  logic convert_start_n = 1, mode_fast = 0, mode_low_power = 0;
  logic range_bipolar = 0, range_ten = 0, bipolar_sel, ten_sel;
  logic [13:0] vin = 14'h0, dac_code, result_code;
  logic [13:0] vals [4] = '{14'h2000, 14'h3FFF, 14'h0000, 14'h1555};
  int n_mismatch = 0, samples_checked = 0;
  sar_ctrl #(.TRIAL_CYC(4), .STALE_CYC(200)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .convert_start_n(convert_start_n),
    .mode_fast(mode_fast), .mode_low_power(mode_low_power),
    .range_bipolar(range_bipolar), .range_ten(range_ten),
    .comp_above(comp), .busy(busy), .sample_track(sample_track),
    .dac_code(dac_code), .result_code(result_code),
    .power_down(power_down), .bipolar_sel(bipolar_sel), .ten_sel(ten_sel));
  sar_afe_model afe (.pclk(pclk), .sample_track(sample_track),
    .dac_code(dac_code), .vin(vin), .comp_above(comp));
  initial begin
    forever #4 pclk = ~pclk;
  end
  // ----------------
  // shared tasks
  // ----------------
  task end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  task hang();
    n_mismatch++;
    $display("BAD %0t wait ran out", $time);
    end_of_test();
  endtask : hang
  task chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 20) hang();
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_acq();
    int k;
    k = 0;
    do begin
      apb(1'b0, `SAR_STAT_OFS, 32'h0);
      k++;
      if (k > 60) hang();
    end while (q[`SAR_STAT_ACQ] !== 1'b1);
  endtask : wait_acq
  task wait_busy(input logic lvl);
    int k;
    k = 0;
    @(negedge pclk);
    while (busy !== lvl) begin
      k++;
      if (k > 200) hang();
      @(negedge pclk);
    end
  endtask : wait_busy
  task too_soon();
    wait_acq();
    @(posedge pclk);
    convert_start_n <= 1'b0;
    repeat (20) @(posedge pclk);
    chk(busy, 1'b0);
    convert_start_n <= 1'b1;
  endtask : too_soon
  task conv(input logic [13:0] v);
    vin <= v;
    repeat (`SAR_NS2CYC(`SAR_PER_LOWP_NS)) @(posedge pclk);
    wait_acq();
    @(posedge pclk);
    convert_start_n <= 1'b0;
    wait_busy(1'b1);
    @(posedge pclk);
    convert_start_n <= 1'b1;
    vin <= ~v;
    wait_busy(1'b0);
    chk(result_code, v);
    apb(1'b0, `SAR_RSLT_OFS, 32'h0);
    chk(q, {18'h0, v});
  endtask : conv
  // ----------------
  // test sequence
  // ----------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SAR_CTRL_OFS, 32'h0);
    chk(q, `SAR_CTRL_RST);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      mode_fast <= i[0];
      mode_low_power <= i[1];
      range_bipolar <= i[0];
      range_ten <= i[1];
      repeat (8) @(posedge pclk);
      wait_acq();
      chk(q[2:1], (i == 1) ? 2'h1 : (i == 2) ? 2'h2 : 2'h0);
      chk(power_down, i == 2);
      chk(bipolar_sel, i[0]);
      chk(ten_sel, i[1]);
      conv(vals[i]);
      apb(1'b0, `SAR_STAT_OFS, 32'h0);
      chk(q[`SAR_STAT_STALE], i == 1);
      if (i == 1) begin
        too_soon();
      end
      $display("pin mode test %0d done", i);
    end
    mode_low_power <= 1'b0;
    range_bipolar <= 1'b0;
    range_ten <= 1'b0;
    apb(1'b1, `SAR_CTRL_OFS, 32'h0000_001D);
    repeat (8) @(posedge pclk);
    wait_acq();
    chk(q[4:1], 4'hE);
    chk(bipolar_sel, 1'b1);
    apb(1'b0, `SAR_CTRL_OFS, 32'h0);
    chk(q, 32'h0000_001D);
    conv(14'h2AAA);
    $display("register mode test done");
    apb(1'b0, 8'h0C, 32'h0);
    chk(e, 1'b1);
    chk(q, 32'h0);
    $display("unmapped test done");
    end_of_test();
  end
endmodule : tb_sar_ctrl
`default_nettype wire
